// ### design/vic_consts.vh
// Constants of the vectored interrupt control block
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define VIC_OFS_MASK 3'h0
`define VIC_OFS_PRIO 3'h1
`define VIC_OFS_REQ 3'h2
`define VIC_OFS_MODE 3'h3
`define VIC_OFS_EVT 3'h4
`define VIC_OFS_EVT_MASK 3'h5
`define VIC_OFS_SRC_LO 3'h6
`define VIC_OFS_SRC_HI 3'h7

// ****************************************
// Fields and reset values
// ****************************************
`define VIC_MODE_GIE 0
`define VIC_MODE_RW_MASK 8'h9f
`define VIC_MODE_RST 8'h00
`define VIC_MASK_RST 8'h00
`define VIC_PRIO_RST 8'h00
`define VIC_LEVEL_UNUSED 5
`define VIC_EVT_GRANT 0
`define VIC_EVT_LOADED 1
`define VIC_HW_CLEAR 17'h0006b

// ****************************************
// ROM addresses
// ****************************************
`define VIC_ROM_TOP 12'hfff
`define VIC_RESET_ADDR 12'h100
`define VIC_ISP_ADDR0 12'h200
`define VIC_ISP_ADDR1 12'h300
`define VIC_ISP_ADDR2 12'h500
`define VIC_ISP_ADDR3 12'h900
`define VIC_VEC_T0_OVF 8'hfa
`define VIC_VEC_T0_MATCH 8'hfc
`define VIC_VEC_T1_OVF 8'hf4
`define VIC_VEC_T1_MATCH 8'hf6
`define VIC_VEC_CNT_A 8'hec
`define VIC_VEC_T2_OVF 8'hf0
`define VIC_VEC_T2_MATCH 8'hf2
`define VIC_VEC_P20 8'hd0
`define VIC_VEC_P00 8'he0
`define VIC_VEC_P01 8'he2
`define VIC_VEC_P02 8'he4
`define VIC_VEC_P03 8'he6
`define VIC_VEC_P0_HI 8'he8

`endif

// ### design/vic_sync.v
// Two-stage synchroniser for asynchronous request inputs
`timescale 1ns/1ps
`default_nettype none
module vic_sync #(
    parameter WIDTH = 17
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Data
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // vic_sync
`default_nettype wire

// ### design/vic_level_arb.v
// Level arbiter: picks the winning level from priority settings
`timescale 1ns/1ps
`default_nettype none
module vic_level_arb (
    // Requests per level, already masked
    input wire [7:0] req,
    input wire [7:0] prio,
    // Winner
    output reg valid,
    output reg [2:0] level
);
    // Rank 0 is served first; level five never ranks
    function [3:0] rank;
        input [2:0] lvl;
        input [7:0] p;
        reg [1:0] grp;
        reg [1:0] sub;
        reg [1:0] gpos;
        begin
            grp = 2'd0;
            sub = 2'd0;
            case (lvl)
                3'd0: begin grp = 2'd0; sub = {1'b0, p[0]}; end
                3'd1: begin grp = 2'd0; sub = {1'b0, ~p[0]}; end
                3'd2: begin grp = 2'd1; sub = 2'd0 - p[2:1]; end
                3'd3: begin grp = 2'd1; sub = 2'd1 - p[2:1]; end
                3'd4: begin grp = 2'd1; sub = 2'd2 - p[2:1]; end
                3'd6: begin grp = 2'd2; sub = {1'b0, p[3]}; end
                3'd7: begin grp = 2'd2; sub = {1'b0, ~p[3]}; end
                default: begin grp = 2'd3; sub = 2'd3; end
            endcase
            // Group B wraps modulo four; the rotation order is kept
            case ({p[5:4], grp})
                4'b00_00, 4'b01_01, 4'b10_10, 4'b11_00: gpos = 2'd0;
                4'b00_01, 4'b01_10, 4'b10_00, 4'b11_10: gpos = 2'd1;
                default: gpos = 2'd2;
            endcase
            rank = (grp == 2'd3) ? 4'hf : {gpos, sub};
        end
    endfunction

    integer i;
    reg [3:0] best;

    always @* begin
        valid = 1'b0;
        level = 3'd0;
        best = 4'hf;
        for (i = 0; i < 8; i = i + 1) begin
            if (req[i] && rank(i[2:0], prio) < best) begin
                best = rank(i[2:0], prio);
                level = i[2:0];
                valid = 1'b1;
            end
        end
    end
endmodule // vic_level_arb
`default_nettype wire

// ### design/vic_top.v
// Vectored interrupt control: levels, vectors, vector fetch
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.vh"
module vic_top (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Register port
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // Core instructions and handshake
    input wire global_enable_instr,
    input wire global_disable_instr,
    input wire cpu_int_ack,
    output reg cpu_int_req_q,
    output reg [7:0] cpu_vector_q,
    output reg stack_push_q,
    // Vector fetch from program ROM
    output reg rom_rd_q,
    output reg [11:0] rom_addr_q,
    input wire [7:0] rom_rdata,
    output reg isr_valid_q,
    output reg [15:0] isr_addr_q,
    // Interrupt sources, asynchronous
    input wire [16:0] src_req,
    output reg sys_reset_req_q,
    // Nonvolatile option straps
    input wire [1:0] in_system_prog_sector,
    input wire opt_reset_reloc,
    output reg [11:0] prog_reset_addr_q,
    output reg [11:0] isp_reset_addr_q,
    // Event interrupt
    output reg irq_q
);
    // ****************************************
    // Fetch sequencer states
    // ****************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_PUSH = 3'd1;
    localparam ST_RD_HI = 3'd2;
    localparam ST_RD_LO = 3'd3;
    localparam ST_LOAD = 3'd4;

    reg [2:0] state_q;
    reg [7:0] level_mask_reg;
    reg [7:0] level_priority_reg;
    reg [7:0] system_mode_reg;
    reg [7:0] evt_q;
    reg [7:0] evt_mask_q;
    reg [16:0] src_prev_q;
    reg [16:1] pend_q;
    reg [4:0] gnt_src_q;
    reg [7:0] hi_byte_q;
    reg opt_taken_q;
    wire [16:0] src_sync;
    wire [16:0] src_rise;
    wire [7:0] levels_zero_to_seven;
    wire [7:0] lvl_req;
    wire arb_valid;
    wire [2:0] arb_level;
    wire wr_hit_src_lo;
    wire wr_hit_src_hi;
    wire grant;
    wire [16:0] hw_clear = `VIC_HW_CLEAR;
    reg [16:1] pend_clr;
    reg [4:0] win_src;
    reg [7:0] win_vec;
    reg [7:0] evt_set;

    // ****************************************
    // Source capture
    // ****************************************
    vic_sync #(
        .WIDTH(17)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d(src_req),
        .q(src_sync)
    );

    assign src_rise = src_sync & ~src_prev_q;

    // Source table in ascending vector order inside each level
    function [7:0] src_vec;
        input [4:0] s;
        begin
            case (s)
                5'd1: src_vec = `VIC_VEC_T0_OVF;
                5'd2: src_vec = `VIC_VEC_T0_MATCH;
                5'd3: src_vec = `VIC_VEC_T1_OVF;
                5'd4: src_vec = `VIC_VEC_T1_MATCH;
                5'd5: src_vec = `VIC_VEC_CNT_A;
                5'd6: src_vec = `VIC_VEC_T2_OVF;
                5'd7: src_vec = `VIC_VEC_T2_MATCH;
                5'd8: src_vec = `VIC_VEC_P20;
                5'd9: src_vec = `VIC_VEC_P00;
                5'd10: src_vec = `VIC_VEC_P01;
                5'd11: src_vec = `VIC_VEC_P02;
                5'd12: src_vec = `VIC_VEC_P03;
                default: src_vec = `VIC_VEC_P0_HI;
            endcase
        end
    endfunction

    // Level pending flags, one per level
    assign levels_zero_to_seven = {
        |pend_q[16:13], |pend_q[12:9], 1'b0, pend_q[8],
        |pend_q[7:6], pend_q[5], |pend_q[4:3], |pend_q[2:1]
    };

    assign lvl_req = levels_zero_to_seven & level_mask_reg &
        ~(8'h01 << `VIC_LEVEL_UNUSED);

    vic_level_arb u_arb (
        .req(lvl_req),
        .prio(level_priority_reg),
        .valid(arb_valid),
        .level(arb_level)
    );

    // Lowest index first means lowest vector first
    always @* begin
        win_src = 5'd13;
        case (arb_level)
            3'd0: win_src = pend_q[1] ? 5'd1 : 5'd2;
            3'd1: win_src = pend_q[3] ? 5'd3 : 5'd4;
            3'd2: win_src = 5'd5;
            3'd3: win_src = pend_q[6] ? 5'd6 : 5'd7;
            3'd4: win_src = 5'd8;
            3'd6: begin
                if (pend_q[9])
                    win_src = 5'd9;
                else if (pend_q[10])
                    win_src = 5'd10;
                else if (pend_q[11])
                    win_src = 5'd11;
                else
                    win_src = 5'd12;
            end
            default: win_src = 5'd13;
        endcase
        win_vec = src_vec(win_src);
    end

    assign grant = (state_q == ST_IDLE) && cpu_int_req_q && cpu_int_ack;
    assign wr_hit_src_lo = reg_wr && reg_addr == `VIC_OFS_SRC_LO;
    assign wr_hit_src_hi = reg_wr && reg_addr == `VIC_OFS_SRC_HI;

    // Software clears pending by writing ones, except for hw_clear sources; the four shared sources
    // keep separate flags so none is lost while another is served.
    always @* begin
        pend_clr = 16'h0000;
        if (wr_hit_src_lo)
            pend_clr[8:1] = reg_wdata & ~hw_clear[8:1];
        if (wr_hit_src_hi)
            pend_clr[16:9] = reg_wdata;
        if (grant && hw_clear[gnt_src_q])
            pend_clr[gnt_src_q] = 1'b1;
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            src_prev_q <= 17'h00000;
            pend_q <= 16'h0000;
            sys_reset_req_q <= 1'b0;
        end else begin
            src_prev_q <= src_sync;
            // A new edge beats a clear in the same cycle
            pend_q <= (pend_q & ~pend_clr) | src_rise[16:1];
            sys_reset_req_q <= src_rise[0];
        end
    end

    // ****************************************
    // Reset address options
    // ****************************************
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            opt_taken_q <= 1'b0;
            prog_reset_addr_q <= `VIC_RESET_ADDR;
            isp_reset_addr_q <= `VIC_ISP_ADDR0;
        end else if (!opt_taken_q) begin
            // Straps are caught once, just after reset release
            opt_taken_q <= 1'b1;
            case (in_system_prog_sector)
                2'd0: isp_reset_addr_q <= `VIC_ISP_ADDR0;
                2'd1: isp_reset_addr_q <= `VIC_ISP_ADDR1;
                2'd2: isp_reset_addr_q <= `VIC_ISP_ADDR2;
                default: isp_reset_addr_q <= `VIC_ISP_ADDR3;
            endcase
            if (opt_reset_reloc)
                prog_reset_addr_q <= isp_addr_of(in_system_prog_sector);
            else
                prog_reset_addr_q <= `VIC_RESET_ADDR;
        end
    end

    function [11:0] isp_addr_of;
        input [1:0] sel;
        begin
            case (sel)
                2'd0: isp_addr_of = `VIC_ISP_ADDR0;
                2'd1: isp_addr_of = `VIC_ISP_ADDR1;
                2'd2: isp_addr_of = `VIC_ISP_ADDR2;
                default: isp_addr_of = `VIC_ISP_ADDR3;
            endcase
        end
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            level_mask_reg <= `VIC_MASK_RST;
            level_priority_reg <= `VIC_PRIO_RST;
            system_mode_reg <= `VIC_MODE_RST;
            evt_mask_q <= 8'h00;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `VIC_OFS_MASK: level_mask_reg <= reg_wdata;
                    `VIC_OFS_PRIO: level_priority_reg <= reg_wdata;
                    `VIC_OFS_MODE:
                        system_mode_reg <= reg_wdata & `VIC_MODE_RW_MASK;
                    `VIC_OFS_EVT_MASK: evt_mask_q <= reg_wdata;
                    default: ;
                endcase
            end
            // Instructions touch bit 0 alone
            if (global_enable_instr)
                system_mode_reg[`VIC_MODE_GIE] <= 1'b1;
            if (global_disable_instr)
                system_mode_reg[`VIC_MODE_GIE] <= 1'b0;
            if (grant)
                system_mode_reg[`VIC_MODE_GIE] <= 1'b0;
        end
    end

    // ****************************************
    // Request to the core and vector fetch
    // ****************************************
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            cpu_int_req_q <= 1'b0;
            cpu_vector_q <= 8'h00;
            gnt_src_q <= 5'd0;
            stack_push_q <= 1'b0;
            rom_rd_q <= 1'b0;
            rom_addr_q <= 12'h000;
            hi_byte_q <= 8'h00;
            isr_valid_q <= 1'b0;
            isr_addr_q <= 16'h0000;
        end else begin
            stack_push_q <= 1'b0;
            rom_rd_q <= 1'b0;
            isr_valid_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (grant) begin
                        cpu_int_req_q <= 1'b0;
                        stack_push_q <= 1'b1;
                        state_q <= ST_PUSH;
                    end else begin
                        // Nothing is offered until global enable is set
                        cpu_int_req_q <= arb_valid &
                            system_mode_reg[`VIC_MODE_GIE];
                        cpu_vector_q <= win_vec;
                        gnt_src_q <= win_src;
                    end
                end
                ST_PUSH: begin
                    rom_rd_q <= 1'b1;
                    rom_addr_q <= {4'h0, cpu_vector_q} & `VIC_ROM_TOP;
                    state_q <= ST_RD_HI;
                end
                ST_RD_HI: begin
                    hi_byte_q <= rom_rdata;
                    rom_rd_q <= 1'b1;
                    rom_addr_q <= rom_addr_q + 12'h001;
                    state_q <= ST_RD_LO;
                end
                ST_RD_LO: begin
                    isr_addr_q <= {hi_byte_q, rom_rdata};
                    isr_valid_q <= 1'b1;
                    state_q <= ST_LOAD;
                end
                ST_LOAD: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Events, interrupt output, read port
    // ****************************************
    always @* begin
        evt_set = 8'h00;
        evt_set[`VIC_EVT_GRANT] = grant;
        evt_set[`VIC_EVT_LOADED] = state_q == ST_RD_LO;
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            evt_q <= 8'h00;
            irq_q <= 1'b0;
            reg_rdata_q <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `VIC_OFS_EVT)
                evt_q <= (evt_q & ~reg_wdata) | evt_set;
            else
                evt_q <= evt_q | evt_set;
            irq_q <= |(evt_q & evt_mask_q);
            reg_rdata_q <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `VIC_OFS_MASK: reg_rdata_q <= level_mask_reg;
                    `VIC_OFS_PRIO: reg_rdata_q <= level_priority_reg;
                    `VIC_OFS_REQ: reg_rdata_q <= levels_zero_to_seven;
                    `VIC_OFS_MODE: reg_rdata_q <= system_mode_reg;
                    `VIC_OFS_EVT: reg_rdata_q <= evt_q;
                    `VIC_OFS_EVT_MASK: reg_rdata_q <= evt_mask_q;
                    `VIC_OFS_SRC_LO: reg_rdata_q <= pend_q[8:1];
                    default: reg_rdata_q <= pend_q[16:9];
                endcase
            end
        end
    end
endmodule // vic_top
`default_nettype wire

// ### testbench/vic_checker.sv
// Concurrent checks on the ports of the vectored interrupt block
`timescale 1ns/1ps
`default_nettype none
module vic_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Core handshake
    input wire logic cpu_int_ack,
    input wire logic cpu_int_req_q,
    input wire logic [7:0] cpu_vector_q,
    input wire logic stack_push_q,
    // Vector fetch
    input wire logic rom_rd_q,
    input wire logic [11:0] rom_addr_q,
    input wire logic isr_valid_q,
    input wire logic [15:0] isr_addr_q,
    // Reset addresses
    input wire logic [11:0] prog_reset_addr_q,
    input wire logic [11:0] isp_reset_addr_q,
    // Reset source
    input wire logic [16:0] src_req,
    input wire logic sys_reset_req_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // ****************
    // Grant and fetch
    // ****************
    chk_grant_push: assert property (
        cpu_int_req_q && cpu_int_ack |=> stack_push_q && !cpu_int_req_q)
        else $error("no stack push after grant");
    chk_offer_gap: assert property (
        stack_push_q |-> !cpu_int_req_q [*4])
        else $error("new offer too soon after grant");
    chk_fetch_addr: assert property (
        cpu_int_req_q && cpu_int_ack |-> ##2
        rom_rd_q && rom_addr_q == {4'h0, $past(cpu_vector_q, 2)})
        else $error("vector fetch address wrong");
    chk_fetch_next: assert property (
        $rose(rom_rd_q) |=>
        rom_rd_q && rom_addr_q == $past(rom_addr_q) + 12'h1)
        else $error("second vector byte not fetched");
    chk_isr_gap: assert property (
        $rose(rom_rd_q) |-> ##2 isr_valid_q)
        else $error("service address late");
    chk_isr_hold: assert property (
        !isr_valid_q |-> $stable(isr_addr_q))
        else $error("service address moved");

    // Relocated reset target must be one of the sector addresses
    chk_reset_addr: assert property (
        prog_reset_addr_q == 12'h100 ||
        prog_reset_addr_q == isp_reset_addr_q)
        else $error("program reset address wrong");
    chk_isp_set: assert property (
        isp_reset_addr_q inside {12'h200, 12'h300, 12'h500, 12'h900})
        else $error("sector reset address wrong");
    // Two sync stages plus the edge flop
    chk_reset_source: assert property (
        $rose(src_req[0]) |-> ##3 sys_reset_req_q)
        else $error("reset source edge not passed on");
endmodule // vic_checker

bind vic_top vic_checker i_vic_checker (.clock, .arst_n, .cpu_int_ack,
    .cpu_int_req_q, .cpu_vector_q, .stack_push_q, .rom_rd_q, .rom_addr_q,
    .isr_valid_q, .isr_addr_q, .prog_reset_addr_q, .isp_reset_addr_q,
    .src_req, .sys_reset_req_q);
`default_nettype wire

// ### testbench/vic_core_model.sv
// Core and program ROM model answering the vector fetch
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Test control
    input wire logic ack_en,
    input wire logic [1:0] ack_wait,
    // Block side
    input wire logic cpu_int_req_q,
    input wire logic rom_rd_q,
    input wire logic [11:0] rom_addr_q,
    output var logic cpu_int_ack,
    output var logic [7:0] rom_rdata
);
    logic [1:0] cnt_q;
    logic [7:0] idle_q;

    // One-cycle grant after a selectable wait, only while offered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cpu_int_ack <= 1'b0;
            cnt_q <= 2'h0;
        end else if (cpu_int_req_q && ack_en && !cpu_int_ack) begin
            cpu_int_ack <= (cnt_q == ack_wait);
            cnt_q <= cnt_q + 2'h1;
        end else begin
            cpu_int_ack <= 1'b0;
            cnt_q <= 2'h0;
        end
    end

    // Idle data toggles so a byte taken outside a read never matches
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            idle_q <= 8'h5a;
        else
            idle_q <= ~idle_q;
    end

    // Read-only ROM answers in the cycle of the read, as the block takes it
    always_comb begin
        rom_rdata = rom_rd_q ? rom_addr_q[7:0] ^ 8'h3c : idle_q;
    end
endmodule // vic_core_model
`default_nettype wire

// ### testbench/vic_top_tb.sv
// Self-checking testbench of the vectored interrupt block
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb;
    logic clock, arst_n, reg_wr, reg_rd, cpu_int_ack, ack_en;
    logic global_enable_instr, global_disable_instr, opt_reset_reloc;
    logic cpu_int_req_q, stack_push_q, rom_rd_q, isr_valid_q, irq_q;
    logic [1:0] in_system_prog_sector, ack_wait;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, cpu_vector_q, rom_rdata;
    logic [7:0] m, p, v, pd;
    logic [11:0] rom_addr_q, prog_reset_addr_q, isp_reset_addr_q, pa, ia;
    logic [15:0] isr_addr_q;
    logic [16:0] src_req, s;
    logic [2:0] sr;
    int errors = 0;
    int tests_run = 0;
    // {mask, priority}, sources, {vector, level pending}
    logic [48:0] rows [29] = '{
        {16'hff00, 17'h2, 16'hfa01}, {16'hff00, 17'h4, 16'hfc01},
        {16'hff00, 17'h8, 16'hf402}, {16'hff00, 17'h10, 16'hf602},
        {16'hff00, 17'h20, 16'hec04}, {16'hff00, 17'h40, 16'hf008},
        {16'hff00, 17'h80, 16'hf208}, {16'hff00, 17'h100, 16'hd010},
        {16'hff00, 17'h200, 16'he040}, {16'hff00, 17'h400, 16'he240},
        {16'hff00, 17'h800, 16'he440}, {16'hff00, 17'h1000, 16'he640},
        {16'hff00, 17'h2000, 16'he880}, {16'hff00, 17'h4000, 16'he880},
        {16'hff00, 17'h8000, 16'he880}, {16'hff00, 17'h10000, 16'he880},
        {16'hff00, 17'h6, 16'hfa01}, {16'hff00, 17'h1e00, 16'he040},
        {16'hff00, 17'h222, 16'hfa45}, {16'hff10, 17'h222, 16'hec45},
        {16'hff20, 17'h222, 16'he045}, {16'hff00, 17'h220, 16'hec44},
        {16'hff30, 17'h220, 16'he044}, {16'hff00, 17'h160, 16'hec1c},
        {16'hff02, 17'h160, 16'hf01c}, {16'hff04, 17'h160, 16'hd01c},
        {16'hff01, 17'ha, 16'hf403}, {16'hff08, 17'h2200, 16'he8c0},
        {16'hfe00, 17'ha, 16'hf403}};
    // {sector, relocate}, program reset, sector reset
    logic [26:0] straps [4] = '{{3'h0, 12'h100, 12'h200},
        {3'h3, 12'h300, 12'h300}, {3'h4, 12'h100, 12'h500},
        {3'h7, 12'h900, 12'h900}};

    vic_top i_vic_top (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .global_enable_instr, .global_disable_instr,
        .cpu_int_ack, .cpu_int_req_q, .cpu_vector_q, .stack_push_q,
        .rom_rd_q, .rom_addr_q, .rom_rdata, .isr_valid_q, .isr_addr_q,
        .src_req, .sys_reset_req_q(), .in_system_prog_sector,
        .opt_reset_reloc, .prog_reset_addr_q, .isp_reset_addr_q, .irq_q);
    vic_core_model i_vic_core_model (.clock, .arst_n, .ack_en, .ack_wait,
        .cpu_int_req_q, .rom_rd_q, .rom_addr_q, .cpu_int_ack, .rom_rdata);

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ****************
    // Bus and checks
    // ****************
    task automatic chk(input string n, input logic [16:0] e, w);
        tests_run++;
        if (w !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, w);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e, string n);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata_q);
    endtask

    task automatic instr(input logic en);
        @(posedge clock);
        global_enable_instr <= en;
        global_disable_instr <= !en;
        @(posedge clock);
        global_enable_instr <= 1'b0;
        global_disable_instr <= 1'b0;
        #1;
    endtask

    // Bounded wait for an offer or for the service address
    task automatic wt(input logic isr);
        int k;
        for (k = 0; k < 20; k++) begin
            if ((isr ? isr_valid_q : cpu_int_req_q) === 1'b1)
                break;
            @(posedge clock);
            #1;
        end
        chk("handshake", 17'h1, k < 20);
    endtask

    task automatic irq_is(input logic e);
        @(posedge clock);
        #1;
        chk("irq", e, irq_q);
    endtask

    // Services whatever is left, hardware-cleared sources included
    task automatic drain();
        wr(3'h0, 8'hff);
        @(posedge clock);
        ack_en <= 1'b1;
        repeat (4) begin
            wr(3'h6, 8'hff);
            wr(3'h7, 8'hff);
            instr(1'b1);
            repeat (12) @(posedge clock);
        end
        ack_en <= 1'b0;
        instr(1'b0);
        rd(3'h2, 8'h00, "drained");
    endtask

    task automatic rst(input int n, input logic [2:0] t);
        @(posedge clock);
        arst_n <= 1'b0;
        {in_system_prog_sector, opt_reset_reloc} <= t;
        repeat (n) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic results();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        results();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        arst_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {global_enable_instr, global_disable_instr} = 2'b00;
        {in_system_prog_sector, opt_reset_reloc} = 3'h0;
        {src_req, ack_en, ack_wait} = '0;
        rst(20, 3'h0);
        rd(3'h0, 8'h00, "mask_reset");
        rd(3'h1, 8'h00, "prio_reset");
        rd(3'h3, 8'h00, "mode_reset");
        for (int i = 0; i < 29; i++) begin
            {m, p, s, v, pd} = rows[i];
            wr(3'h0, m);
            wr(3'h1, p);
            @(posedge clock);
            src_req <= s;
            ack_wait <= i[1:0];
            instr(1'b1);
            wt(1'b0);
            chk("vector", v, cpu_vector_q);
            rd(3'h2, pd, "level_pending");
            @(posedge clock);
            ack_en <= 1'b1;
            src_req <= 17'h0;
            #1;
            wt(1'b1);
            chk("isr", {v ^ 8'h3c, (v + 8'h1) ^ 8'h3c}, isr_addr_q);
            rd(3'h3, 8'h00, "mode_grant");
            if ($onehot(s)) begin
                rd(3'h6, s[8:1] & 8'hca, "src_lo");
                rd(3'h7, s[16:9], "src_hi");
            end
            drain();
        end
        @(posedge clock);
        src_req <= 17'h00201;
        repeat (8) @(posedge clock);
        #1;
        chk("no_offer", 17'h0, cpu_int_req_q);
        wr(3'h2, 8'hff);
        rd(3'h2, 8'h40, "read_only");
        wr(3'h3, 8'hfe);
        rd(3'h3, 8'h9e, "mode_rw");
        instr(1'b1);
        rd(3'h3, 8'h9f, "mode_ei");
        wt(1'b0);
        instr(1'b0);
        rd(3'h3, 8'h9e, "mode_di");
        wr(3'h3, 8'h00);
        @(posedge clock);
        src_req <= 17'h0;
        drain();
        wr(3'h5, 8'h00);
        irq_is(1'b0);
        wr(3'h5, 8'h03);
        irq_is(1'b1);
        rd(3'h4, 8'h03, "event");
        wr(3'h4, 8'h03);
        irq_is(1'b0);
        for (int i = 0; i < 4; i++) begin
            {sr, pa, ia} = straps[i];
            rst(2, sr);
            chk("prog_reset", pa, prog_reset_addr_q);
            chk("isp_reset", ia, isp_reset_addr_q);
        end
        results();
    end
endmodule // vic_top_tb
`default_nettype wire
